// >>> pkg/pq_pkg.sv
// constants and register map of the line power-quality monitor
package pq_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_RESULT    = 8'h0a;
  localparam logic [7:0] IDX_MODE_ONE  = 8'h0b;
  localparam logic [7:0] IDX_MODE_TWO  = 8'h0c;
  localparam logic [7:0] IDX_ZX_TOUT   = 8'h11;
  localparam logic [7:0] IDX_SAG_CYC   = 8'h13;
  localparam logic [7:0] IDX_SAG_LVL   = 8'h14;
  localparam logic [7:0] IDX_IPK_LVL   = 8'h15;
  localparam logic [7:0] IDX_VPK_LVL   = 8'h16;
  localparam logic [7:0] IDX_MIRQ_EN   = 8'hdb;
  localparam logic [7:0] IDX_MIRQ_ST   = 8'hde;
  localparam logic [7:0] IDX_PSM_EN    = 8'hec;
  localparam logic [7:0] IDX_PSM_FLAGS = 8'hf8;
  localparam int         ADDR_W        = 10;
  // field positions
  localparam int BIT_INTEG     = 5;  // mode one: integrator enable
  localparam int BIT_PF_BYPASS = 4;  // mode one: prefilter bypass
  localparam int BIT_PERIOD_FREQUENCY_SELECT   = 1;  // mode two: 1 = frequency
  localparam int BIT_ROUTE_P05 = 6;  // mode two: zero cross on port0 bit5
  localparam int BIT_ROUTE_P12 = 7;  // mode two: zero cross on port1 bit2
  localparam int BIT_ZX        = 0;  // status/enable three
  localparam int BIT_TIMEOUT_STATUS_FLAG      = 1;
  localparam int BIT_PKV       = 3;
  localparam int BIT_PKI       = 4;
  localparam int BIT_SAG       = 5;  // power-management flags/enable
  localparam logic [7:0] MIRQ_MASK = 8'h1b;  // implemented status bits
  localparam logic [7:0] PSM_MASK  = 8'h20;
  // reset values
  localparam logic [11:0] ZX_TOUT_RST = 12'hfff;
  localparam logic [7:0]  SAG_CYC_RST = 8'h04;
  // timing
  localparam int          TOUT_DIV   = 160;  // clocks per timeout decrement
  localparam int          PERIOD_DIV = 10;   // clocks per period tick
  localparam int          FREQ_LSB_PER_HZ = 16;  // frequency result lsb is 1/16 hz
  localparam logic [15:0] SAT16      = 16'hffff;
endpackage : pq_pkg

// >>> hw/voltage_prefilter.sv
// single-pole low-pass prefilter for the voltage samples
`timescale 1ns/1ps
`default_nettype none
module voltage_prefilter #(
  parameter int SHIFT = 6  // pole position: y += (x - y) / 2^SHIFT
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // sample in
  input  wire logic               in_valid,
  input  wire logic signed [23:0] in_sample,
  // filtered sample out, valid the cycle after in_valid
  output logic signed [23:0]      out_sample
);
  typedef struct packed {
    logic signed [31:0] acc;  // filter state with guard bits
  } pf_s;

  pf_s                st_reg;
  pf_s                st_next;
  logic signed [31:0] diff;  // input minus state, scaled

  // one filter step per valid sample
  always_comb begin
    st_next = st_reg;
    diff    = (32'(in_sample) <<< 8) - st_reg.acc;
    if (in_valid) begin
      st_next.acc = st_reg.acc + (diff >>> SHIFT);
    end
  end

  // state register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_sample = st_reg.acc[31:8];
endmodule : voltage_prefilter
`default_nettype wire

// >>> hw/line_power_quality_monitor.sv
// line power-quality monitor: zero cross, timeout, period/frequency, sag, peaks, apb registers
`timescale 1ns/1ps
`default_nettype none
module line_power_quality_monitor
  import pq_pkg::*;
#(
  parameter int CLK_HZ    = 4096000,  // measurement clock rate
  parameter int PF_SHIFT  = 6         // prefilter pole
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [pq_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic [31:0]                prdata,
  // channel samples
  input  wire logic                  v_valid,
  input  wire logic signed [23:0]    v_sample,
  input  wire logic                  i_valid,
  input  wire logic signed [23:0]    i_sample,
  // outputs to the rest of the chip
  output logic                       integrator_enable,
  output logic                       zero_cross,
  output logic                       port0_bit5,
  output logic                       port1_bit2,
  output logic                       meas_irq,
  output logic                       psm_irq
);
  import pq_pkg::*;

  localparam logic [31:0] FREQ_NUM = 32'(FREQ_LSB_PER_HZ * (CLK_HZ / PERIOD_DIV));

  typedef struct packed {
    logic [7:0]         mode_one;
    logic [7:0]         mode_two;
    logic [11:0]        zx_tout;     // programmed timeout
    logic [7:0]         sag_cyc;
    logic [15:0]        sag_lvl;
    logic [15:0]        ipk_lvl;
    logic [15:0]        vpk_lvl;
    logic [7:0]         mirq_en;
    logic [7:0]         mirq_st;
    logic [7:0]         psm_en;
    logic [7:0]         psm_flags;
    logic [15:0]        result;      // period or frequency
    logic signed [23:0] v_raw;       // held raw voltage sample
    logic               chk;         // evaluate zero cross this cycle
    logic               zx_lvl;      // sign of detector input
    logic               zx_primed;   // a first level is known, so edges are real
    logic [7:0]         tdiv;        // timeout prescaler
    logic [11:0]        tcnt;        // timeout down counter
    logic               tdone;       // timeout already reported
    logic [3:0]         pdiv;        // period prescaler
    logic [15:0]        pcnt;        // ticks in current period
    logic [15:0]        cyc_peak;    // prefilter peak this cycle
    logic [7:0]         sag_n;       // low cycles seen
    logic               div_busy;
    logic [5:0]         div_i;
    logic [31:0]        div_n;
    logic [31:0]        div_q;
    logic [16:0]        div_r;
    logic [15:0]        div_d;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
    logic               meas_irq;
    logic               psm_irq;
    logic               integ;
    logic               p05;
    logic               p12;
  } mon_s;

  mon_s               st_reg;
  mon_s               st_next;
  logic signed [23:0] v_filt;      // prefilter output
  logic signed [23:0] zx_in;       // detector input
  logic [15:0]        sag_mag;     // prefilter magnitude
  logic [15:0]        v_mag;       // raw voltage magnitude
  logic [15:0]        i_mag;       // current top two bytes magnitude
  logic [15:0]        sag_eff;     // effective sag level
  logic               zx_evt;      // rising zero cross this cycle
  logic               acc_wr;      // apb write takes effect
  logic [7:0]         widx;        // register index of access
  logic [16:0]        rem2;        // divider trial remainder
  logic [7:0]         mst_set;     // status bits set by events
  logic               sag_set;

  // prefilter on the voltage channel
  voltage_prefilter #(
    .SHIFT      (PF_SHIFT)
  ) u_prefilter (
    .clk        (clk),
    .reset      (reset),
    .in_valid   (v_valid),
    .in_sample  (v_sample),
    .out_sample (v_filt)
  );

  // magnitude of the upper 16 bits of a sample
  function automatic logic [15:0] mag16(input logic signed [23:0] s);
    logic [15:0] t;
    t = s[23:8];
    return s[23] ? 16'(-t) : t;
  endfunction : mag16

  // datapath helpers
  always_comb begin
    zx_in   = st_reg.mode_one[BIT_PF_BYPASS] ? st_reg.v_raw : v_filt;
    sag_mag = mag16(v_filt);
    v_mag   = mag16(v_sample);
    i_mag   = mag16(i_sample);
    sag_eff = (st_reg.sag_lvl <= 16'h0001) ? 16'h0000 : st_reg.sag_lvl;
    zx_evt  = st_reg.chk && st_reg.zx_primed && !st_reg.zx_lvl && !zx_in[23];
    widx    = 8'(paddr >> 2);
    acc_wr  = psel && penable && st_reg.pready && pwrite && !st_reg.pslverr;
    rem2    = {st_reg.div_r[15:0], st_reg.div_n[31]};
  end

  // next state
  always_comb begin
    st_next = st_reg;
    mst_set = '0;
    sag_set = 1'b0;
    // zero-cross detector, evaluated one cycle after each voltage sample
    st_next.chk = v_valid;
    if (v_valid) begin
      st_next.v_raw = v_sample;
    end
    if (st_reg.chk) begin
      st_next.zx_lvl    = !zx_in[23];
      st_next.zx_primed = 1'b1;  // no false crossing on the first sample after reset
    end
    if (zx_evt) begin
      mst_set[BIT_ZX] = 1'b1;
    end
    // timeout counter
    st_next.tdiv = (st_reg.tdiv == 8'(TOUT_DIV - 1)) ? '0 : st_reg.tdiv + 8'h01;
    if (zx_evt) begin
      st_next.tcnt  = st_reg.zx_tout;
      st_next.tdone = 1'b0;
    end else if (st_reg.tcnt == '0) begin
      if (!st_reg.tdone) begin
        mst_set[BIT_TIMEOUT_STATUS_FLAG] = 1'b1;
        st_next.tdone     = 1'b1;
      end
    end else if (st_reg.tdiv == 8'(TOUT_DIV - 1)) begin
      st_next.tcnt = st_reg.tcnt - 12'h001;
    end
    // period measurement in ticks of clk / 10
    st_next.pdiv = (st_reg.pdiv == 4'(PERIOD_DIV - 1)) ? '0 : st_reg.pdiv + 4'h1;
    if (st_reg.pdiv == 4'(PERIOD_DIV - 1) && st_reg.pcnt != SAT16) begin
      st_next.pcnt = st_reg.pcnt + 16'h0001;
    end
    if (zx_evt) begin
      st_next.pcnt = '0;
      if (st_reg.mode_two[BIT_PERIOD_FREQUENCY_SELECT]) begin
        st_next.div_busy = 1'b1;
        st_next.div_i    = '0;
        st_next.div_n    = FREQ_NUM;
        st_next.div_q    = '0;
        st_next.div_r    = '0;
        st_next.div_d    = st_reg.pcnt;
      end else begin
        st_next.result = st_reg.pcnt;
      end
    end
    // restoring divider: frequency = FREQ_NUM / period ticks
    if (st_reg.div_busy && !zx_evt) begin
      st_next.div_n = {st_reg.div_n[30:0], 1'b0};
      if (rem2 >= {1'b0, st_reg.div_d}) begin
        st_next.div_r = rem2 - {1'b0, st_reg.div_d};
        st_next.div_q = {st_reg.div_q[30:0], 1'b1};
      end else begin
        st_next.div_r = rem2;
        st_next.div_q = {st_reg.div_q[30:0], 1'b0};
      end
      st_next.div_i = st_reg.div_i + 6'h01;
      if (st_reg.div_i == 6'd31) begin
        st_next.div_busy = 1'b0;
        st_next.result   = (st_next.div_q[31:16] != '0) ? SAT16 : st_next.div_q[15:0];
      end
    end
    // sag: track prefilter peak over each line cycle
    if (st_reg.chk && sag_mag > st_reg.cyc_peak) begin
      st_next.cyc_peak = sag_mag;
    end
    if (zx_evt) begin
      st_next.cyc_peak = '0;
      if (st_reg.cyc_peak < sag_eff) begin
        if (st_reg.sag_n != 8'hff) begin
          st_next.sag_n = st_reg.sag_n + 8'h01;
        end
        if (st_reg.sag_n + 8'h01 == st_reg.sag_cyc - 8'h01) begin
          sag_set = 1'b1;
        end
      end else begin
        st_next.sag_n = '0;
      end
    end
    // peak detectors, both channels at once
    if (v_valid && v_mag > st_reg.vpk_lvl) begin
      mst_set[BIT_PKV] = 1'b1;
    end
    if (i_valid && i_mag > st_reg.ipk_lvl) begin
      mst_set[BIT_PKI] = 1'b1;
    end
    // apb: answer one cycle into the access phase
    st_next.pready  = psel && !penable;
    st_next.pslverr = 1'b0;
    if (psel && !penable) begin
      st_next.prdata = '0;
      if (widx == IDX_RESULT) begin
        st_next.prdata[15:0] = st_reg.result;
      end else if (widx == IDX_MODE_ONE) begin
        st_next.prdata[7:0] = st_reg.mode_one;
      end else if (widx == IDX_MODE_TWO) begin
        st_next.prdata[7:0] = st_reg.mode_two;
      end else if (widx == IDX_ZX_TOUT) begin
        st_next.prdata[11:0] = st_reg.zx_tout;
      end else if (widx == IDX_SAG_CYC) begin
        st_next.prdata[7:0] = st_reg.sag_cyc;
      end else if (widx == IDX_SAG_LVL) begin
        st_next.prdata[15:0] = st_reg.sag_lvl;
      end else if (widx == IDX_IPK_LVL) begin
        st_next.prdata[15:0] = st_reg.ipk_lvl;
      end else if (widx == IDX_VPK_LVL) begin
        st_next.prdata[15:0] = st_reg.vpk_lvl;
      end else if (widx == IDX_MIRQ_EN) begin
        st_next.prdata[7:0] = st_reg.mirq_en;
      end else if (widx == IDX_MIRQ_ST) begin
        st_next.prdata[7:0] = st_reg.mirq_st;
      end else if (widx == IDX_PSM_EN) begin
        st_next.prdata[7:0] = st_reg.psm_en;
      end else if (widx == IDX_PSM_FLAGS) begin
        st_next.prdata[7:0] = st_reg.psm_flags;
      end else begin
        st_next.pslverr = 1'b1;  // unmapped index
      end
      if (paddr[1:0] != 2'b00) begin
        st_next.pslverr = 1'b1;
      end
    end
    if (acc_wr) begin
      if (widx == IDX_MODE_ONE) begin
        st_next.mode_one = pwdata[7:0];
      end else if (widx == IDX_MODE_TWO) begin
        st_next.mode_two = pwdata[7:0];
      end else if (widx == IDX_ZX_TOUT) begin
        st_next.zx_tout = pwdata[11:0];
      end else if (widx == IDX_SAG_CYC) begin
        st_next.sag_cyc = pwdata[7:0];
      end else if (widx == IDX_SAG_LVL) begin
        st_next.sag_lvl = pwdata[15:0];
      end else if (widx == IDX_IPK_LVL) begin
        st_next.ipk_lvl = pwdata[15:0];
      end else if (widx == IDX_VPK_LVL) begin
        st_next.vpk_lvl = pwdata[15:0];
      end else if (widx == IDX_MIRQ_EN) begin
        st_next.mirq_en = pwdata[7:0] & MIRQ_MASK;
      end else if (widx == IDX_MIRQ_ST) begin
        st_next.mirq_st = st_reg.mirq_st & ~pwdata[7:0];  // write one to clear
      end else if (widx == IDX_PSM_EN) begin
        st_next.psm_en = pwdata[7:0] & PSM_MASK;
      end else if (widx == IDX_PSM_FLAGS) begin
        st_next.psm_flags = st_reg.psm_flags & ~pwdata[7:0];
      end
    end
    // hardware set wins over a same-cycle clear
    st_next.mirq_st          = st_next.mirq_st | mst_set;
    st_next.psm_flags[BIT_SAG] = st_next.psm_flags[BIT_SAG] | sag_set;
    // registered outputs
    st_next.meas_irq = |(st_reg.mirq_st & st_reg.mirq_en);
    st_next.psm_irq  = |(st_reg.psm_flags & st_reg.psm_en);
    st_next.integ    = st_reg.mode_one[BIT_INTEG];
    st_next.p05      = st_reg.mode_two[BIT_ROUTE_P05] && st_reg.zx_lvl;
    st_next.p12      = st_reg.mode_two[BIT_ROUTE_P12] && st_reg.zx_lvl;
  end

  // state register, power-on defaults
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg         <= '0;
      st_reg.zx_tout <= ZX_TOUT_RST;
      st_reg.tcnt    <= ZX_TOUT_RST;
      st_reg.sag_cyc <= SAG_CYC_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pready            = st_reg.pready;
  assign pslverr           = st_reg.pslverr;
  assign prdata            = st_reg.prdata;
  assign integrator_enable = st_reg.integ;
  assign zero_cross        = st_reg.zx_lvl;
  assign port0_bit5        = st_reg.p05;
  assign port1_bit2        = st_reg.p12;
  assign meas_irq          = st_reg.meas_irq;
  assign psm_irq           = st_reg.psm_irq;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_integ_follow: assert property (integrator_enable == $past(st_reg.mode_one[BIT_INTEG]))
    else $error("integrator enable does not follow mode bit");
  a_zx_flag: assert property (zx_evt |=> st_reg.mirq_st[BIT_ZX])
    else $error("zero cross flag not set");
  a_tout_reload: assert property (zx_evt |=> st_reg.tcnt == $past(st_reg.zx_tout))
    else $error("timeout not reloaded on zero cross");
  a_tout_step: assert property (!zx_evt && st_reg.tcnt != '0 && st_reg.tdiv == 8'(TOUT_DIV - 1)
    |=> st_reg.tcnt == $past(st_reg.tcnt) - 12'h001)
    else $error("timeout counter step wrong");
  a_tout_flag: assert property (!zx_evt && st_reg.tcnt == '0 && !st_reg.tdone |=> st_reg.mirq_st[BIT_TIMEOUT_STATUS_FLAG])
    else $error("timeout flag not set at zero");
  a_period_upd: assert property (zx_evt && !st_reg.mode_two[BIT_PERIOD_FREQUENCY_SELECT] |=> st_reg.result == $past(st_reg.pcnt))
    else $error("period result not updated");
  a_irq_or: assert property (##1 meas_irq == |($past(st_reg.mirq_st) & $past(st_reg.mirq_en)))
    else $error("measurement irq mismatch");
  a_sag_restart: assert property (zx_evt && st_reg.cyc_peak >= sag_eff |=> st_reg.sag_n == '0)
    else $error("sag count not restarted");
  a_vpk_flag: assert property (v_valid && v_mag > st_reg.vpk_lvl |=> st_reg.mirq_st[BIT_PKV])
    else $error("voltage peak flag not set");
  a_ipk_flag: assert property (i_valid && i_mag > st_reg.ipk_lvl |=> st_reg.mirq_st[BIT_PKI])
    else $error("current peak flag not set");
  a_sag_flag: assert property (sag_set |=> st_reg.psm_flags[BIT_SAG]
    ##1 psm_irq == $past(st_reg.psm_en[BIT_SAG]))
    else $error("sag flag or psm irq wrong");

  c_zero_cross: cover property (zx_evt);
  c_timeout:    cover property (st_reg.mirq_st[BIT_TIMEOUT_STATUS_FLAG]);
  c_sag:        cover property (sag_set);
  c_freq_done:  cover property (st_reg.div_busy ##1 !st_reg.div_busy);
endmodule : line_power_quality_monitor
`default_nettype wire

// >>> tb/test_line_power_quality_monitor.sv
// self-checking bench of the line power-quality monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; $display("BAD %0t got %h want %h", $time, a, e); end end
module test_line_power_quality_monitor;
  import pq_pkg::*;
  // clock, reset and apb
  logic               clk, reset, psel, penable, pwrite, pready, pslverr, re;
  logic [ADDR_W-1:0]  paddr;
  logic [31:0]        pwdata, prdata, rv, r, seed;
  // channel samples and chip outputs
  logic               v_valid, i_valid, integrator_enable, zero_cross, port0_bit5, port1_bit2;
  logic               meas_irq, psm_irq, run;
  logic signed [23:0] v_sample, i_sample, vamp, iamp;
  logic [15:0]        t;
  int                 err_total, cmp_count, halfp, ph, n;

  line_power_quality_monitor #(.PF_SHIFT(2)) dut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .v_valid(v_valid),
    .v_sample(v_sample), .i_valid(i_valid), .i_sample(i_sample), .integrator_enable(integrator_enable),
    .zero_cross(zero_cross), .port0_bit5(port0_bit5), .port1_bit2(port1_bit2), .meas_irq(meas_irq),
    .psm_irq(psm_irq));

  // 40 mhz clock
  always #12.5 clk = ~clk;

  // square-wave line of period 2*halfp, dc level while run is low; a sample every other cycle
  always @(posedge clk) begin
    ph <= (ph >= 2 * halfp - 1) ? 0 : ph + 1;
    v_valid <= ph[0];
    i_valid <= ph[0];
    v_sample <= (run && ph >= halfp) ? -vamp : vamp;
    i_sample <= iamp;
  end

  // xorshift source, fixed seed
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // true when a lies within tol of e
  function automatic logic near(input logic [31:0] a, input logic [31:0] e, input logic [31:0] tol);
    return (a + tol >= e) && (a <= e + tol);
  endfunction : near

  // one apb transfer: setup, then access until pready; read data and error kept in rv, re
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang here
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // wait, bounded, until the zero-cross output shows val
  task automatic wzx(input logic val);
    int k;
    k = 0;
    while (zero_cross !== val && k < 9000) begin
      @(posedge clk);
      k++;
    end
    if (zero_cross !== val) begin
      err_total++;
      $display("BAD %0t zero cross output stuck", $time);
    end
  endtask : wzx

  // counts and verdict, then stop
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  // watchdog well past the expected run of about 45k cycles
  initial begin
    #(90000 * 25);
    err_total++;
    finish_test();
  end

  initial begin
    clk = 0; reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    v_valid = 0; i_valid = 0; v_sample = 0; i_sample = 0; vamp = 24'h000100; iamp = 0; run = 0;
    halfp = 1000; ph = 0; seed = 32'hd75d; err_total = 0; cmp_count = 0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    // reset values, integrator switch, timeout register round trip, unmapped index
    apb(0, IDX_ZX_TOUT, 0);
    `CHK(rv[11:0], ZX_TOUT_RST)
    `CHK(integrator_enable, 1'b0)
    apb(1, IDX_MODE_ONE, 32'h20);
    repeat (2) @(posedge clk);
    `CHK(integrator_enable, 1'b1)
    for (n = 0; n < 4; n++) begin
      r = xs();
      apb(1, IDX_ZX_TOUT, {20'h0, r[11:0]});
      apb(0, IDX_ZX_TOUT, 0);
      `CHK(rv, {20'h0, r[11:0]})
    end
    apb(0, 8'h01, 0);
    `CHK(re, 1'b1)
    $display("registers done");
    // peaks: a level equal to the threshold is no event, one above is; current by magnitude
    apb(1, IDX_MIRQ_EN, 32'h18);
    for (n = 0; n < 3; n++) begin
      r = xs();
      t = {4'h0, r[11:0]} + 16'h10;
      vamp <= {t, 8'h00};
      iamp <= -{t, 8'h00};
      apb(1, IDX_VPK_LVL, {16'h0, t});
      apb(1, IDX_IPK_LVL, {16'h0, t});
      apb(1, IDX_MIRQ_ST, 32'hff);
      repeat (6) @(posedge clk);
      apb(0, IDX_MIRQ_ST, 0);
      `CHK(rv[4:3], 2'b00)
      `CHK(meas_irq, 1'b0)
      vamp <= {t + 16'h1, 8'h00};
      iamp <= -{t + 16'h1, 8'h00};
      repeat (6) @(posedge clk);
      apb(0, IDX_MIRQ_ST, 0);
      `CHK(rv[4:3], 2'b11)
      `CHK(meas_irq, 1'b1)
      vamp <= 24'h000100;
      iamp <= 24'h0;
      apb(1, IDX_MIRQ_ST, 32'h18);
      repeat (4) @(posedge clk);
      `CHK(meas_irq, 1'b0)
    end
    $display("peaks done");
    // raw zero crossing with the prefilter bypassed, routed to the first port bit only
    apb(1, IDX_MODE_ONE, 32'h10);
    apb(1, IDX_MODE_TWO, 32'h40);
    apb(1, IDX_ZX_TOUT, 32'd20);
    apb(1, IDX_MIRQ_EN, 32'h01);
    vamp <= 24'h100000;
    run <= 1'b1;
    wzx(1'b0);
    apb(1, IDX_MIRQ_ST, 32'hff);
    wzx(1'b1);
    repeat (4) @(posedge clk);
    `CHK({zero_cross, port0_bit5, port1_bit2, meas_irq}, 4'b1101)
    // route to the second port bit only, still in the high half of the line
    apb(1, IDX_MODE_TWO, 32'h80);
    repeat (2) @(posedge clk);
    `CHK({port0_bit5, port1_bit2}, 2'b01)
    // one result per line period, in tenths of the clock, then in sixteenths of a hertz
    repeat (3 * 2000) @(posedge clk);
    apb(0, IDX_RESULT, 0);
    `CHK(near(rv, 200, 1), 1'b1)
    halfp <= 1500;
    repeat (3 * 3000) @(posedge clk);
    apb(0, IDX_RESULT, 0);
    `CHK(near(rv, 300, 1), 1'b1)
    apb(1, IDX_MODE_TWO, 32'h42);
    repeat (2 * 3000) @(posedge clk);
    apb(0, IDX_RESULT, 0);
    `CHK(near(rv, 16 * (4096000 / 10) / 300, 4), 1'b1)
    $display("period done");
    // line stops after a crossing: timeout expires 19 to 20 steps of 160 clocks later
    apb(1, IDX_MODE_TWO, 32'h00);
    apb(1, IDX_MIRQ_EN, 32'h02);
    apb(1, IDX_MIRQ_ST, 32'hff);
    wzx(1'b0);
    wzx(1'b1);
    run <= 1'b0;
    n = 0;
    while (meas_irq !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    `CHK(n >= 19 * TOUT_DIV - 4 && n <= 20 * TOUT_DIV + 4, 1'b1)
    $display("timeout done");
    // sag with a count of four flags after three low cycles; a level of one never sags
    apb(1, IDX_MODE_ONE, 32'h00);
    apb(1, IDX_PSM_EN, 32'h20);
    apb(1, IDX_SAG_LVL, 32'h0800);
    apb(1, IDX_SAG_CYC, 32'h04);
    halfp <= 500;
    run <= 1'b1;
    repeat (3000) @(posedge clk);
    apb(1, IDX_PSM_FLAGS, 32'hff);
    vamp <= 24'h020000;
    repeat (2200) @(posedge clk);
    `CHK(psm_irq, 1'b0)
    repeat (3000) @(posedge clk);
    apb(0, IDX_PSM_FLAGS, 0);
    `CHK({rv[5], psm_irq}, 2'b11)
    apb(1, IDX_SAG_LVL, 32'h0001);
    apb(1, IDX_PSM_FLAGS, 32'hff);
    repeat (6000) @(posedge clk);
    `CHK(psm_irq, 1'b0)
    $display("sag done");
    finish_test();
  end
endmodule : test_line_power_quality_monitor
`default_nettype wire
